// ==== design/pms_sequencer.v ====
// proximity measurement sequencer: emitter pulsing, conversion, thresholds, wait, sleep
// assumes APB host at mclk; analog front end data and saturation arrive asynchronously
// the emitter and interrupt pins are open drain: only their enables ever move
//
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "pms_defs.vh"
module pms_sequencer #(
	parameter STEP_CYCLES = `PMS_STEP_CYC,
	parameter PULSE_ON_CYCLES = `PMS_PULSE_ON_CYC,
	parameter PULSE_PER_CYCLES = `PMS_PULSE_PER_CYC,
	parameter CNT_W = 20
) (
	input wire mclk,
	input wire resetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire [15:0] adc_wideband_channel,
	input wire [15:0] adc_infrared_channel,
	input wire adc_saturated,
	output reg adc_integrate,
	output reg adc_chan_ir,
	output reg [1:0] adc_gain,
	output reg emitter_sink_out,
	output reg emitter_sink_oe,
	output reg int_n_out,
	output reg int_n_oe,
	output reg irq
);
	localparam ST_IDLE = 3'd0;
	localparam ST_PULSE = 3'd1;
	localparam ST_INTEG = 3'd2;
	localparam ST_EVAL = 3'd3;
	localparam ST_WAIT = 3'd4;
	localparam ST_SLEEP = 3'd5;

	// host map, one word per register, unused upper bits read zero except enable bit 4, which reads back as written
	//   00 enable: power, measure, wait between cycles, sleep after interrupt
	//   04 integration time, steps are 256 minus the field
	//   08 wait time, same step rule, bit 8 multiplies the step count by twelve
	//   0C thresholds, lower bound low half, upper bound high half
	//   10 persistence, consecutive misses before the threshold flag
	//   14 config: pulse count, analog gain, channel select
	//   18 crosstalk offset removed from every sample
	//   1C status, read only, any read clears what was set before it
	//   20 last result, updated only at the end of a conversion
	//   24 interrupt mask, same layout as status
	// a value written while a conversion runs takes effect at once, so
	// software should clear the power bit, which aborts a running conversion, before changing the setup
	// host-visible control registers
	reg [4:0] enable_reg;
	reg [7:0] itime_reg;
	reg [8:0] wtime_reg;
	reg [15:0] thr_lo_reg;
	reg [15:0] thr_hi_reg;
	reg [3:0] persist_reg;
	reg [7:0] pulses_reg;
	reg [1:0] gain_reg;
	reg chan_reg;
	reg [15:0] offset_reg;
	reg [2:0] status_reg;
	reg [2:0] imask_reg;
	reg [15:0] result_reg;
	// sequencer state and its counters
	reg [2:0] state_reg;
	reg [CNT_W-1:0] cyc_reg;
	reg [11:0] step_reg;
	reg [7:0] pulse_cnt_reg;
	reg [3:0] pers_cnt_reg;
	reg sat_seen_reg;
	// second flop of each front end synchroniser
	wire [15:0] wide_s2_reg;
	wire [15:0] ir_s2_reg;
	wire sat_s2_reg;

	// decode of the completing access phase
	wire apb_done = psel & penable & pready;
	wire wr_en = apb_done & pwrite;
	wire rd_status = apb_done & ~pwrite & (paddr == `PMS_STATUS_OFF);
	wire addr_ok = (paddr == `PMS_ENABLE_OFF) || (paddr == `PMS_ITIME_OFF) ||
		(paddr == `PMS_WTIME_OFF) || (paddr == `PMS_THRESH_OFF) ||
		(paddr == `PMS_PERSIST_OFF) || (paddr == `PMS_CONFIG_OFF) ||
		(paddr == `PMS_OFFSET_OFF) || (paddr == `PMS_STATUS_OFF) ||
		(paddr == `PMS_RESULT_OFF) || (paddr == `PMS_IMASK_OFF);

	// selected channel after offset removal, clamped at zero
	// an offset larger than the sample reads as zero rather than wrapping
	wire [15:0] raw_sample = chan_reg ? ir_s2_reg : wide_s2_reg;
	wire [15:0] corrected = (raw_sample > offset_reg) ?
		(raw_sample - offset_reg) : 16'h0000;
	wire out_of_range = (corrected > thr_hi_reg) || (corrected < thr_lo_reg);
	wire pers_hit = (pers_cnt_reg + 4'h1) >= persist_reg;
	wire eval_now = (state_reg == ST_EVAL);
	wire thresh_event = eval_now & out_of_range & pers_hit;

	// integration steps 1..256 from itime, wait steps with optional x12 stretch
	// a zero itime field gives the longest integration, 256 steps
	wire [8:0] integ_steps = 9'h100 - {1'b0, itime_reg};
	wire [8:0] wait_base = 9'h100 - {1'b0, wtime_reg[7:0]};
	// 256 x 12 still fits in 12 bits, so the cut below loses nothing
	wire [31:0] wait_long = wait_base * `PMS_WAIT_LONG_MUL;
	wire [11:0] wait_steps = wtime_reg[`PMS_WTIME_LONG] ?
		wait_long[11:0] : {3'h0, wait_base};
	wire step_end = (cyc_reg == STEP_CYCLES[CNT_W-1:0] - 1'b1);

	// analog inputs come from another domain, two flops before any use;
	// a word that changes mid-capture can tear, so the front end holds it steady
	pms_sync #(.W(16)) pms_sync_wide_inst (
		.mclk(mclk),
		.resetn(resetn),
		.d(adc_wideband_channel),
		.q_reg(wide_s2_reg)
	);
	pms_sync #(.W(16)) pms_sync_ir_inst (
		.mclk(mclk),
		.resetn(resetn),
		.d(adc_infrared_channel),
		.q_reg(ir_s2_reg)
	);
	pms_sync #(.W(1)) pms_sync_sat_inst (
		.mclk(mclk),
		.resetn(resetn),
		.d(adc_saturated),
		.q_reg(sat_s2_reg)
	);

	// apb slave: one wait state so read data can come from a flop
	// pready is a one-cycle pulse; the master holds its request until then
	// the read word is latched in the wait cycle of every access, read or write, and holds until the next access
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else if (psel & penable & ~pready) begin
			pready <= 1'b1;
			pslverr <= ~addr_ok;
			case (paddr)
			`PMS_ENABLE_OFF: prdata <= {27'h0, enable_reg};
			`PMS_ITIME_OFF: prdata <= {24'h0, itime_reg};
			`PMS_WTIME_OFF: prdata <= {23'h0, wtime_reg};
			`PMS_THRESH_OFF: prdata <= {thr_hi_reg, thr_lo_reg};
			`PMS_PERSIST_OFF: prdata <= {28'h0, persist_reg};
			`PMS_CONFIG_OFF: prdata <= {19'h0, chan_reg, 2'b00, gain_reg, pulses_reg};
			`PMS_OFFSET_OFF: prdata <= {16'h0, offset_reg};
			`PMS_STATUS_OFF: prdata <= {29'h0, status_reg};
			`PMS_RESULT_OFF: prdata <= {16'h0, result_reg};
			`PMS_IMASK_OFF: prdata <= {29'h0, imask_reg};
			default: prdata <= 32'h00000000;
			endcase
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// control registers written at the completing access edge
	// status and result are read only: a write to them is accepted and ignored
	// an unmapped write is flagged through pslverr and changes nothing
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			enable_reg <= `PMS_ENABLE_RST;
			itime_reg <= `PMS_ITIME_RST;
			wtime_reg <= `PMS_WTIME_RST;
			thr_lo_reg <= `PMS_THR_LO_RST;
			thr_hi_reg <= `PMS_THR_HI_RST;
			persist_reg <= 4'h0;
			pulses_reg <= `PMS_PULSE_RST;
			gain_reg <= 2'b00;
			chan_reg <= 1'b0;
			offset_reg <= 16'h0000;
			imask_reg <= 3'b000;
		end else if (wr_en) begin
			case (paddr)
			`PMS_ENABLE_OFF: enable_reg <= pwdata[4:0];
			`PMS_ITIME_OFF: itime_reg <= pwdata[7:0];
			`PMS_WTIME_OFF: wtime_reg <= pwdata[8:0];
			`PMS_THRESH_OFF: begin
				thr_lo_reg <= pwdata[15:0];
				thr_hi_reg <= pwdata[31:16];
			end
			`PMS_PERSIST_OFF: persist_reg <= pwdata[3:0];
			`PMS_CONFIG_OFF: begin
				// zero pulses is not allowed, forced to one
				pulses_reg <= (pwdata[7:0] == 8'h00) ? 8'h01 : pwdata[7:0];
				gain_reg <= pwdata[`PMS_CFG_GAIN_LSB +: 2];
				chan_reg <= pwdata[`PMS_CFG_CHAN];
			end
			`PMS_OFFSET_OFF: offset_reg <= pwdata[15:0];
			`PMS_IMASK_OFF: imask_reg <= pwdata[2:0];
			default: ;
			endcase
		end
	end

	// sticky status: a read clears, but a same-cycle event still sets,
	// so an event that lands on the clearing read is never lost; the flags
	// are valid result, threshold crossing and front end overload
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			status_reg <= 3'b000;
		end else begin
			status_reg <= (rd_status ? 3'b000 : status_reg) |
				{eval_now & sat_seen_reg, thresh_event, eval_now};
		end
	end

	// measurement sequencer: idle, pulse train, integration, one evaluate cycle,
	// then wait, sleep or straight back to idle; clearing power aborts any state
	// the pulse and step counters share cyc_reg, which restarts at every change
	// of state, so one counter covers the longest span of a single step
	// sleep is left through the status read that clears the threshold flag, or by clearing power
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= ST_IDLE;
			cyc_reg <= {CNT_W{1'b0}};
			step_reg <= 12'h000;
			pulse_cnt_reg <= 8'h00;
			pers_cnt_reg <= 4'h0;
			sat_seen_reg <= 1'b0;
			result_reg <= 16'h0000;
		end else begin
			case (state_reg)
			// idle: clear cycle and pulse counters, start when powered and measuring
			ST_IDLE: begin
				cyc_reg <= {CNT_W{1'b0}};
				pulse_cnt_reg <= 8'h00;
				sat_seen_reg <= 1'b0;
				if (enable_reg[`PMS_EN_POWER] & enable_reg[`PMS_EN_MEAS])
					state_reg <= ST_PULSE;
			end

			// pulse train, one fixed period per programmed pulse
			ST_PULSE: begin
				// fixed pulse period, sink on for the leading part only
				if (cyc_reg == PULSE_PER_CYCLES[CNT_W-1:0] - 1'b1) begin
					cyc_reg <= {CNT_W{1'b0}};
					if (pulse_cnt_reg == pulses_reg - 8'h01) begin
						step_reg <= 12'h000;
						state_reg <= ST_INTEG;
					end else begin
						pulse_cnt_reg <= pulse_cnt_reg + 8'h01;
					end
				end else begin
					cyc_reg <= cyc_reg + 1'b1;
				end
			end

			// integration: count steps, note any overload on the way
			ST_INTEG: begin
				if (sat_s2_reg)
					sat_seen_reg <= 1'b1;
				if (step_end) begin
					cyc_reg <= {CNT_W{1'b0}};
					if (step_reg == {3'h0, integ_steps} - 12'h001)
						state_reg <= ST_EVAL;
					else
						step_reg <= step_reg + 12'h001;
				end else begin
					cyc_reg <= cyc_reg + 1'b1;
				end
			end

			// evaluate: latch result, update persistence, pick next state
			ST_EVAL: begin
				result_reg <= corrected;
				// persistence counts consecutive misses only
				// and restarts after it has fired, so a long miss run fires every N
				if (!out_of_range)
					pers_cnt_reg <= 4'h0;
				else if (!pers_hit)
					pers_cnt_reg <= pers_cnt_reg + 4'h1;
				else
					pers_cnt_reg <= 4'h0;
				cyc_reg <= {CNT_W{1'b0}};
				step_reg <= 12'h000;
				if (thresh_event & enable_reg[`PMS_EN_SLEEP_INT])
					state_reg <= ST_SLEEP;
				else if (enable_reg[`PMS_EN_WAIT])
					state_reg <= ST_WAIT;
				else
					state_reg <= ST_IDLE;
			end

			// wait: programmed number of steps, then start over
			ST_WAIT: begin
				if (step_end) begin
					cyc_reg <= {CNT_W{1'b0}};
					if (step_reg == wait_steps - 12'h001)
						state_reg <= ST_IDLE;
					else
						step_reg <= step_reg + 12'h001;
				end else begin
					cyc_reg <= cyc_reg + 1'b1;
				end
			end

			// sleep after interrupt: no measuring until the flag is read away
			ST_SLEEP: begin
				// stays asleep until firmware clears the threshold flag
				if (!status_reg[`PMS_ST_THRESH])
					state_reg <= ST_IDLE;
			end
			default: state_reg <= ST_IDLE;
			endcase
			if (!enable_reg[`PMS_EN_POWER])
				state_reg <= ST_IDLE;
		end
	end

	// pin drivers: open-drain pins only ever drive low
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			emitter_sink_out <= 1'b0;
			emitter_sink_oe <= 1'b0;
			adc_integrate <= 1'b0;
			adc_chan_ir <= 1'b0;
			adc_gain <= 2'b00;
		end else begin
			emitter_sink_out <= 1'b0;
			emitter_sink_oe <= (state_reg == ST_PULSE) &
				(cyc_reg < PULSE_ON_CYCLES[CNT_W-1:0]);
			adc_integrate <= (state_reg == ST_INTEG);
			adc_chan_ir <= chan_reg;
			adc_gain <= gain_reg;
		end
	end

	// interrupt pin and level, registered from the masked status so the
	// pin never shows a decode glitch
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			int_n_out <= 1'b0;
			int_n_oe <= 1'b0;
			irq <= 1'b0;
		end else begin
			int_n_out <= 1'b0;
			int_n_oe <= |(status_reg & imask_reg);
			irq <= |(status_reg & imask_reg);
		end
	end
endmodule

// two-flop synchroniser for a bus of quasi-static bits
module pms_sync #(
	parameter W = 1
) (
	input wire mclk,
	input wire resetn,
	input wire [W-1:0] d,
	output reg [W-1:0] q_reg
);
	reg [W-1:0] meta_reg;

	// only the second stage is ever read by logic
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			meta_reg <= {W{1'b0}};
			q_reg <= {W{1'b0}};
		end else begin
			meta_reg <= d;
			q_reg <= meta_reg;
		end
	end
endmodule
`default_nettype wire

// ==== design/pms_defs.vh ====
// constants of the proximity measurement sequencer: register map, fields, timing
// assumes a 40 MHz mclk and a 32-bit APB host port
// Notes on behaviour
// - each emitter pulse holds the sink on for about seven microseconds
// - pulses per measurement programmable from 1 to 255
// - only the host-selected photodiode channel, wideband or infrared, is converted
// - the conversion result is up to 16 bits wide
// - result registers update only when a conversion cycle completes
// - host and device exchange all register traffic over the host port
// - interrupt is a level on its own output pin
// - enabled interrupt fires on results above upper or below lower threshold
// - interrupt stays asserted until host firmware clears it
// - interrupt needs a programmable count of consecutive out-of-range results
// - interrupt pin is open drain, active low, pulled low when asserted
// - emitter output is an open-drain sink, on only during pulses
// - programmable wait between measurements, 2.7 ms up to beyond 8 s
// - sleep-after-interrupt mode stops measuring once the interrupt fires; the code sleeps on the threshold flag, masked or not
// - saturation status bit set when the front end saturated
// - host-programmed offset is subtracted to cancel optical crosstalk
// - gain and integration time applied to every conversion
// - integration time selects 1 to 256 steps
`ifndef PMS_DEFS_VH
`define PMS_DEFS_VH
// register byte offsets
`define PMS_ENABLE_OFF 8'h00
`define PMS_ITIME_OFF 8'h04
`define PMS_WTIME_OFF 8'h08
`define PMS_THRESH_OFF 8'h0C
`define PMS_PERSIST_OFF 8'h10
`define PMS_CONFIG_OFF 8'h14
`define PMS_OFFSET_OFF 8'h18
`define PMS_STATUS_OFF 8'h1C
`define PMS_RESULT_OFF 8'h20
`define PMS_IMASK_OFF 8'h24
// enable register fields
`define PMS_EN_POWER 0
`define PMS_EN_MEAS 1
`define PMS_EN_WAIT 2
`define PMS_EN_SLEEP_INT 3
// config and wait-time register fields
`define PMS_CFG_PULSE_LSB 0
`define PMS_CFG_GAIN_LSB 8
`define PMS_CFG_CHAN 12
`define PMS_WTIME_LONG 8
// status bits (sticky, read clears)
`define PMS_ST_VALID 0
`define PMS_ST_THRESH 1
`define PMS_ST_SAT 2
// reset values
`define PMS_ENABLE_RST 5'h00
`define PMS_ITIME_RST 8'hFF
`define PMS_WTIME_RST 9'h0FF
`define PMS_PULSE_RST 8'h01
`define PMS_THR_LO_RST 16'h0000
`define PMS_THR_HI_RST 16'hFFFF
// timing, printed figures then cycles at 40 MHz
`define PMS_CLK_MHZ 40
`define PMS_PULSE_ON_NS 7300
`define PMS_PULSE_PER_NS 16000
`define PMS_STEP_NS 2730000
`define PMS_PULSE_ON_CYC ((`PMS_PULSE_ON_NS * `PMS_CLK_MHZ) / 1000)
`define PMS_PULSE_PER_CYC ((`PMS_PULSE_PER_NS * `PMS_CLK_MHZ) / 1000)
`define PMS_STEP_CYC ((`PMS_STEP_NS * `PMS_CLK_MHZ) / 1000)
`define PMS_WAIT_LONG_MUL 12
`endif

// ==== verif/pms_seq_sva.sv ====
// checker: apb answer, emitter pulses, interrupt pin
// assumes binding onto pms_sequencer
`timescale 1ns/100ps
`default_nettype none
module pms_seq_sva #(
	parameter PULSE_ON_CYCLES = 292
) (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic adc_integrate,
	input wire logic adc_chan_ir,
	input wire logic [1:0] adc_gain,
	input wire logic emitter_sink_out,
	input wire logic emitter_sink_oe,
	input wire logic int_n_out,
	input wire logic int_n_oe,
	input wire logic irq
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	// accepted access, and the two accesses that may drop the interrupt
	wire acc = psel && penable;
	wire clr = acc && pready && (pwrite ? paddr == 8'h24 : paddr == 8'h1C);
	reg [8:0] on_cnt;
	// length of the current sink pulse, wide enough for the full-rate figure
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) on_cnt <= 9'h000;
		else on_cnt <= emitter_sink_oe ? on_cnt + 9'h001 : 9'h000;
	end
	ready_one_a: assert property (pready |=> !pready) else $error("pready held");
	ready_late_a: assert property (acc && !pready |=> pready) else $error("late pready");
	err_ready_a: assert property (pslverr |-> pready) else $error("lone pslverr");
	pulse_len_a: assert property ($fell(emitter_sink_oe) |-> on_cnt == PULSE_ON_CYCLES)
		else $error("pulse width");
	sink_idle_a: assert property (emitter_sink_oe |-> !adc_integrate && !emitter_sink_out)
		else $error("sink outside pulse");
	int_pin_a: assert property (irq == (int_n_oe && !int_n_out)) else $error("int pin");
	int_hold_a: assert property ($fell(irq) |-> $past(clr) || $past(clr, 2))
		else $error("irq dropped alone");
	set_hold_a: assert property (adc_integrate && $past(adc_integrate) |->
		$stable(adc_gain) && $stable(adc_chan_ir)) else $error("setting moved");
endmodule
bind pms_sequencer pms_seq_sva #(.PULSE_ON_CYCLES(PULSE_ON_CYCLES)) pms_seq_sva_inst (
	.mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pready(pready), .pslverr(pslverr), .adc_integrate(adc_integrate),
	.adc_chan_ir(adc_chan_ir), .adc_gain(adc_gain), .emitter_sink_out(emitter_sink_out),
	.emitter_sink_oe(emitter_sink_oe), .int_n_out(int_n_out), .int_n_oe(int_n_oe),
	.irq(irq));
`default_nettype wire

// ==== verif/pms_front_model.sv ====
// analog front end stand-in: both photodiode words and overload flag
// assumes the integrate strobe of the sequencer
`timescale 1ns/100ps
`default_nettype none
module pms_front_model (
	input wire logic adc_integrate,
	input wire logic sat_req,
	input wire logic [15:0] wb_val,
	input wire logic [15:0] ir_val,
	output logic [15:0] adc_wideband_channel,
	output logic [15:0] adc_infrared_channel,
	output logic adc_saturated
);
	// both words present at once, so a wrong pick shows in the result
	assign adc_wideband_channel = wb_val;
	assign adc_infrared_channel = ir_val;
	// overload only shows while integrating
	assign adc_saturated = sat_req && adc_integrate;
endmodule
`default_nettype wire

// ==== verif/proximity_measurement_sequencer_test.sv ====
// self-checking bench for the measurement sequencer over apb
// assumes shortened step and pulse counts so a one-pulse measurement takes tens of cycles
`timescale 1ns/100ps
`default_nettype none
module proximity_measurement_sequencer_test;
	logic resetn, psel, penable, pwrite, sat_req, err, mclk;
	logic [7:0] paddr;
	logic [31:0] pwdata, rdat;
	logic [15:0] wb_val, ir_val;
	wire [31:0] prdata;
	wire [15:0] adc_wb, adc_ir;
	wire [1:0] adc_gain;
	wire pready, pslverr, adc_sat, adc_integrate, adc_chan_ir;
	wire sink_out, sink_oe, int_out, int_oe, irq;
	int fail_count, comparisons, pc, cc, n, g, off, p, np, gap;
	realtime t_fall;
	// pulled-up open-drain pin as the board sees it
	wire int_pin = int_oe ? int_out : 1'h1;
	pms_sequencer #(.STEP_CYCLES(20), .PULSE_ON_CYCLES(4), .PULSE_PER_CYCLES(8)) pms_sequencer_inst (
		.mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.adc_wideband_channel(adc_wb), .adc_infrared_channel(adc_ir), .adc_saturated(adc_sat),
		.adc_integrate(adc_integrate), .adc_chan_ir(adc_chan_ir), .adc_gain(adc_gain),
		.emitter_sink_out(sink_out), .emitter_sink_oe(sink_oe), .int_n_out(int_out),
		.int_n_oe(int_oe), .irq(irq));
	pms_front_model pms_front_model_inst (.adc_integrate(adc_integrate), .sat_req(sat_req),
		.wb_val(wb_val), .ir_val(ir_val), .adc_wideband_channel(adc_wb),
		.adc_infrared_channel(adc_ir), .adc_saturated(adc_sat));
	// clock, and counters of pulses and finished conversions
	initial begin
		mclk = 1'h0;
		forever #12.5 mclk = ~mclk;
	end
	always @(posedge sink_oe) pc = pc + 1;
	always @(negedge adc_integrate) begin
		cc = cc + 1;
		t_fall = $realtime;
	end
	// cycles from one conversion's end to the next one's start
	always @(posedge adc_integrate) gap = int'(($realtime - t_fall) / 25.0);
	function automatic logic [15:0] fexp(input logic [15:0] v, input logic [15:0] o);
		return v > o ? v - o : 16'h0000;
	endfunction
	// eval, wait steps of 20 cycles, idle, one 8-cycle pulse period
	function automatic int wgap(input logic [8:0] wt);
		return (256 - wt[7:0]) * (wt[8] ? 12 : 1) * 20 + 10;
	endfunction
	task automatic final_report;
		if (fail_count == 0 && comparisons > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// one apb transfer; an idle edge first so no signal is driven twice at one edge
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int k;
		@(posedge mclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'h1;
		k = 0;
		do begin
			@(posedge mclk);
			k++;
		end while (pready !== 1'h1 && k < 20);
		rdat = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (k == 20) chk(k, 0);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(a, 1'h1, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(a, 1'h0, 32'h0);
		chk(rdat, e);
	endtask
	// bounded wait, a measurement at 255 pulses needs about 2100 cycles
	task automatic wait_irq;
		n = 0;
		while (irq !== 1'h1 && n < 5000) begin
			@(posedge mclk);
			n++;
		end
		if (n == 5000) chk(n, 0);
	endtask
	// watchdog well past the expected few thousand cycles
	initial begin
		repeat (20000) @(posedge mclk);
		fail_count++;
		final_report;
	end
	initial begin
		{resetn, psel, penable, pwrite, sat_req, paddr, pwdata, wb_val, ir_val} = 0;
		fail_count = 0;
		comparisons = 0;
		n = $urandom(32'h3388);
		repeat (4) @(posedge mclk);
		resetn <= 1'h1;
		// reset contents, unmapped word, zero pulses taken as one
		rd(8'h00, 32'h0);
		rd(8'h04, 32'hFF);
		rd(8'h0C, 32'hFFFF_0000);
		apb(8'h30, 1'h0, 32'h0);
		chk(err, 1);
		chk(rdat, 0);
		wr(8'h14, 32'h0);
		rd(8'h14, 32'h1);
		// one measurement per channel at both pulse-count limits, overload on the second
		for (int k = 0; k < 2; k++) begin
			wb_val <= $urandom;
			ir_val <= $urandom;
			sat_req <= k;
			g = $urandom % 4;
			off = $urandom % 4096;
			p = k ? 255 : 1;
			wr(8'h18, off);
			wr(8'h24, 32'h1);
			wr(8'h0C, 32'hFFFF_0000);
			wr(8'h14, (k << 12) | (g << 8) | p);
			pc = 0;
			wr(8'h00, 32'h7);
			wait_irq;
			np = pc;
			chk(int_pin, 0);
			chk(adc_chan_ir, k);
			chk(adc_gain, g);
			wr(8'h00, 32'h0);
			chk(np, p);
			rd(8'h20, fexp(k ? ir_val : wb_val, off[15:0]));
			rd(8'h1C, k ? 32'h5 : 32'h1);
			repeat (2) @(posedge mclk);
			chk(irq, 0);
		end
		// above the upper, then below the lower bound, with persistence and sleep
		for (int j = 0; j < 2; j++) begin
			wb_val <= 16'h1000 + $urandom % 16'h6000;
			sat_req <= 1'h0;
			np = 2 + j;
			wr(8'h18, 32'h0);
			wr(8'h14, 32'h1);
			wr(8'h08, j ? 32'h1FE : 32'h0FE);
			wr(8'h0C, j ? 32'hFFFF_FFFF : 32'h0100_0000);
			wr(8'h10, np);
			wr(8'h24, 32'h2);
			cc = 0;
			wr(8'h00, 32'hF);
			wait_irq;
			chk(cc, np);
			chk(gap, wgap(j ? 9'h1FE : 9'h0FE));
			repeat (200) @(posedge mclk);
			chk(cc, np);
			wr(8'h00, 32'h0);
			rd(8'h1C, 32'h3);
			repeat (2) @(posedge mclk);
			chk(irq, 0);
		end
		final_report;
	end
endmodule
`default_nettype wire
